// [rtl/ppc_pkg.sv]
/*
  Shared constants for the channel port group control block:
  word layouts, link codes, far-end register map and reset values.
  Assumes 16-bit processor words and eight channel ports.
*/
package ppc_pkg;

  // Group size and word width
  localparam int PORT_COUNT = 8;
  localparam int WORD_W     = 16;

  // Select/connect word layout
  localparam int         CONN_LO      = 12;
  localparam logic [3:0] CONNECT_CODE = 4'h3;
  localparam int         COUPLER_BIT  = 8;

  // Command word layout
  localparam int CMD_CLR_IRQ = 11;
  localparam int CMD_PCLR    = 12;
  localparam int CMD_CODE_HI = 13;
  localparam int CMD_CODE_LO = 14;
  localparam int CMD_STROBE  = 15;

  // Status word layouts
  localparam int PS_CPL_ERR  = 0;
  localparam int PS_BANK_W4  = 1;
  localparam int PS_BANK_W2  = 2;
  localparam int PS_BANK_W1  = 3;
  localparam int PS_PORT_LO  = 8;
  localparam int CS_ANY_ERR  = 0;
  localparam int CS_IRQ_LO   = 8;

  // Control codes, first bit has weight 2
  localparam logic [1:0] CODE_INVALID  = 2'h0;
  localparam logic [1:0] CODE_CHAN_FLG = 2'h1;
  localparam logic [1:0] CODE_EXT_FLG  = 2'h2;
  localparam logic [1:0] CODE_SUSPEND  = 2'h3;

  // Far-end register offsets (byte addresses)
  localparam logic [11:0] REG_STATUS   = 12'h000;
  localparam logic [11:0] REG_MASK     = 12'h004;
  localparam logic [11:0] REG_IRQ_SEND = 12'h008;
  localparam logic [11:0] REG_CODES    = 12'h00c;

  // Far-end status fields, one byte each
  localparam int ST_EXT_LO  = 0;
  localparam int ST_CHAN_LO = 8;
  localparam int ST_SUSP_LO = 16;
  localparam int ST_INV_LO  = 24;

  // Reset values
  localparam logic [15:0] WORD_RST  = 16'h0000;
  localparam logic [31:0] REG32_RST = 32'h0000_0000;

endpackage

// [rtl/ppc_link_if.sv]
/*
  Link between the port group and the peripheral station ends.
  Both ends share one clock; the bench joins them through this.
*/
`timescale 1ns/1ps
`default_nettype none

interface ppc_link_if;
  import ppc_pkg::*;
  logic [1:0]            code;
  logic [PORT_COUNT-1:0] strobe;
  logic [PORT_COUNT-1:0] periph_irq;

  // Port group end
  modport dev (output code, output strobe, input periph_irq);
  // Peripheral station end
  modport far (input code, input strobe, output periph_irq);
endinterface

`default_nettype wire

// [rtl/ppc_port_group.sv]
/*
  Port group end: the eight channel ports plus the processor-side
  coupler as seen by the station control processor through two
  output words and two input words.
  Assumes single-cycle write strobes from the processor, parity
  error pulses from each port, and one shared clock with the link.
*/
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Select bits 0..7 pick ports 8..1
// - Only selected port obeys processor control
// - Group connected only with code in C..F
// - Connection lasts while code 3 held
// - Bit B set-then-clear clears port interrupt
// - Bit C set-then-clear program clears port
// - Bits D,E carry 2-bit control code
// - Bit F sends control code to far end
// - Parity word bit 0: coupler parity error
// - Bits 1..3: selected bank, weights 4,2,1
// - Bits 8..F: port 1..8 parity errors
// - Composite bit 0: any parity error
// - Composite bits 8..F: pending port interrupts
// - Processor connects, selects, then strobes code
// - Control codes only through channel ports
// - Far end acts on flag/suspend codes
// - Peripheral interrupt held in own status bit
module ppc_port_group
  import ppc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    ce,
  // Link to peripheral ends
  ppc_link_if.dev                      link,
  // Processor output words
  input  wire logic                    sel_wr,
  input  wire logic                    cmd_wr,
  input  wire logic [WORD_W-1:0]       wr_data,
  // Processor input words
  output logic      [WORD_W-1:0]       parity_status_word,
  output logic      [WORD_W-1:0]       composite_status_word,
  // Port-side events
  input  wire logic [PORT_COUNT-1:0]   port_par_err,
  input  wire logic [3*PORT_COUNT-1:0] port_bank,
  input  wire logic                    cpl_par_err,
  input  wire logic [2:0]              cpl_bank,
  // Operation selection clears
  output logic      [PORT_COUNT-1:0]   op_clear,
  output logic                         cpl_op_clear
);

  // Held output words
  logic [WORD_W-1:0] sel_r, sel_nxt;
  logic [WORD_W-1:0] cmd_r, cmd_nxt;

  // Per-port state
  logic [PORT_COUNT-1:0]      err_r, err_nxt;
  logic [PORT_COUNT-1:0][2:0] bank_r, bank_nxt;
  logic [PORT_COUNT-1:0]      irq_r, irq_nxt;
  logic                       cpl_err_r, cpl_err_nxt;
  logic [2:0]                 cpl_bank_r, cpl_bank_nxt;

  // Link and processor-facing outputs
  logic [1:0]            code_r, code_nxt;
  logic [PORT_COUNT-1:0] strobe_r, strobe_nxt;
  logic [PORT_COUNT-1:0] opclr_r, opclr_nxt;
  logic                  cpl_opclr_r, cpl_opclr_nxt;
  logic [WORD_W-1:0]     ps_r, ps_nxt;
  logic [WORD_W-1:0]     cs_r, cs_nxt;

  // Decode of the held words
  logic                  connected;
  logic [PORT_COUNT-1:0] sel_vec;
  logic                  one_hot;
  logic                  cpl_sel;
  logic [PORT_COUNT-1:0] tgt;
  logic                  clr_irq_ev;
  logic                  pclr_ev;
  logic                  strobe_ev;
  logic [2:0]            sel_bank;

  // Group connect and one-hot port select
  always_comb begin
    // Bit 12 carries weight 8 of the connect code, bit 15 weight 1
    connected = ({sel_r[CONN_LO],   sel_r[CONN_LO+1],
                  sel_r[CONN_LO+2], sel_r[CONN_LO+3]} ==
                 CONNECT_CODE);
    for (int i = 0; i < PORT_COUNT; i++) begin
      sel_vec[i] = sel_r[PORT_COUNT-1-i];
    end
    one_hot = (sel_vec != '0) &&
              ((sel_vec & (sel_vec - 1'b1)) == '0);
    // Coupler only when no channel port is selected alongside
    cpl_sel = connected && sel_r[COUPLER_BIT] && (sel_vec == '0);
    // Two ports at once would fight over the bank field
    tgt     = (connected && one_hot) ? sel_vec : '0;
  end

  // Command bit edges, old word against the word being written
  always_comb begin
    clr_irq_ev = ce && cmd_wr && cmd_r[CMD_CLR_IRQ] &&
                 !wr_data[CMD_CLR_IRQ];
    pclr_ev    = ce && cmd_wr && cmd_r[CMD_PCLR] &&
                 !wr_data[CMD_PCLR];
    strobe_ev  = ce && cmd_wr && !cmd_r[CMD_STROBE] &&
                 wr_data[CMD_STROBE];
  end

  // Held words: the processor keeps them until rewritten
  always_comb begin
    sel_nxt = sel_r;
    cmd_nxt = cmd_r;
    if (sel_wr) begin
      sel_nxt = wr_data;
    end
    if (cmd_wr) begin
      cmd_nxt = wr_data;
    end
  end

  // Port state; a new event wins over a clear in the same cycle
  always_comb begin
    err_nxt    = err_r;
    bank_nxt   = bank_r;
    irq_nxt    = irq_r;
    opclr_nxt  = '0;
    strobe_nxt = '0;
    code_nxt   = code_r;
    for (int i = 0; i < PORT_COUNT; i++) begin
      if (pclr_ev && tgt[i]) begin
        err_nxt[i]   = 1'b0;
        bank_nxt[i]  = 3'h0;
        opclr_nxt[i] = 1'b1;
      end
      // First failing bank is kept until program clear
      if (port_par_err[i] && (!err_r[i] || (pclr_ev && tgt[i]))) begin
        err_nxt[i]  = 1'b1;
        bank_nxt[i] = port_bank[3*i +: 3];
      end
      if (clr_irq_ev && tgt[i]) begin
        irq_nxt[i] = 1'b0;
      end
      if (link.periph_irq[i]) begin
        irq_nxt[i] = 1'b1;
      end
      // Coupler select never reaches the link
      strobe_nxt[i] = strobe_ev && tgt[i];
    end
    if (strobe_ev && (tgt != '0)) begin
      code_nxt = {wr_data[CMD_CODE_HI],
                  wr_data[CMD_CODE_LO]};
    end
  end

  // Processor-side coupler: program clear only, no codes
  always_comb begin
    cpl_err_nxt   = cpl_err_r;
    cpl_bank_nxt  = cpl_bank_r;
    cpl_opclr_nxt = pclr_ev && cpl_sel;
    if (pclr_ev && cpl_sel) begin
      cpl_err_nxt  = 1'b0;
      cpl_bank_nxt = 3'h0;
    end
    if (cpl_par_err && (!cpl_err_r || (pclr_ev && cpl_sel))) begin
      cpl_err_nxt  = 1'b1;
      cpl_bank_nxt = cpl_bank;
    end
  end

  // Bank count of whichever interface is selected
  always_comb begin
    sel_bank = 3'h0;
    if (cpl_sel) begin
      sel_bank = cpl_bank_nxt;
    end
    for (int i = 0; i < PORT_COUNT; i++) begin
      if (tgt[i]) begin
        sel_bank = bank_nxt[i];
      end
    end
  end

  // Input words; a group not connected reads all zero
  always_comb begin
    ps_nxt = WORD_RST;
    cs_nxt = WORD_RST;
    if (connected) begin
      ps_nxt[PS_CPL_ERR] = cpl_err_nxt;
      ps_nxt[PS_BANK_W4] = sel_bank[2];
      ps_nxt[PS_BANK_W2] = sel_bank[1];
      ps_nxt[PS_BANK_W1] = sel_bank[0];
      ps_nxt[PS_PORT_LO +: PORT_COUNT] = err_nxt;
      cs_nxt[CS_ANY_ERR] = (|err_nxt) | cpl_err_nxt;
      cs_nxt[CS_IRQ_LO +: PORT_COUNT]  = irq_nxt;
    end
  end

  // State registers, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r       <= WORD_RST;
      cmd_r       <= WORD_RST;
      err_r       <= '0;
      bank_r      <= '0;
      irq_r       <= '0;
      cpl_err_r   <= 1'b0;
      cpl_bank_r  <= 3'h0;
      code_r      <= CODE_INVALID;
      strobe_r    <= '0;
      opclr_r     <= '0;
      cpl_opclr_r <= 1'b0;
      ps_r        <= WORD_RST;
      cs_r        <= WORD_RST;
    end else if (ce) begin
      sel_r       <= sel_nxt;
      cmd_r       <= cmd_nxt;
      err_r       <= err_nxt;
      bank_r      <= bank_nxt;
      irq_r       <= irq_nxt;
      cpl_err_r   <= cpl_err_nxt;
      cpl_bank_r  <= cpl_bank_nxt;
      code_r      <= code_nxt;
      strobe_r    <= strobe_nxt;
      opclr_r     <= opclr_nxt;
      cpl_opclr_r <= cpl_opclr_nxt;
      ps_r        <= ps_nxt;
      cs_r        <= cs_nxt;
    end
  end

  // Outputs straight from flops
  assign link.code             = code_r;
  assign link.strobe           = strobe_r;
  assign parity_status_word    = ps_r;
  assign composite_status_word = cs_r;
  assign op_clear              = opclr_r;
  assign cpl_op_clear          = cpl_opclr_r;

endmodule

`default_nettype wire

// [rtl/ppc_station_end.sv]
/*
  Peripheral station end for all eight channels: receives control
  codes, acts on them and raises interrupts toward the port group.
  Software reaches it over an APB slave with one wait state.
*/
`timescale 1ns/1ps
`default_nettype none

module ppc_station_end
  import ppc_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // Clock, reset, enable
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  // Link to port group
  ppc_link_if.far                    link,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Station actions and interrupt
  output logic      [PORT_COUNT-1:0] mclr,
  output logic      [PORT_COUNT-1:0] autoload,
  output logic      [PORT_COUNT-1:0] msg_read,
  output logic      [PORT_COUNT-1:0] xfer_end,
  output logic                       irq
);

  logic [31:0]           sts_r, sts_nxt;
  logic [31:0]           mask_r, mask_nxt;
  logic [15:0]           codes_r, codes_nxt;
  logic [PORT_COUNT-1:0] pirq_r, pirq_nxt;
  logic [PORT_COUNT-1:0] mclr_r, mclr_nxt;
  logic [PORT_COUNT-1:0] aload_r;
  logic [PORT_COUNT-1:0] msg_r, msg_nxt;
  logic [PORT_COUNT-1:0] end_r, end_nxt;
  logic [PORT_COUNT-1:0] inv_ev;
  logic                  irq_r, irq_nxt;
  logic [31:0]           rd_r, rd_nxt;
  logic                  rdy_r, rdy_nxt;
  logic                  err_r, err_nxt;
  logic                  acc;
  logic                  wr_done;
  logic [11:0]           addr;

  // One wait state: answer in the second access cycle
  always_comb begin
    addr    = 12'(paddr);
    acc     = psel && penable && !rdy_r;
    wr_done = psel && penable && rdy_r && pwrite && !err_r;
    rdy_nxt = acc;
    rd_nxt  = rd_r;
    err_nxt = 1'b0;
    if (acc) begin
      rd_nxt = REG32_RST;
      case (addr)
        REG_STATUS:   rd_nxt = sts_r;
        REG_MASK:     rd_nxt = mask_r;
        REG_IRQ_SEND: rd_nxt = REG32_RST;
        REG_CODES:    rd_nxt = {16'h0000, codes_r};
        default:      err_nxt = 1'b1;
      endcase
    end
  end

  // Code decode per channel and the resulting status
  always_comb begin
    mclr_nxt  = '0;
    msg_nxt   = '0;
    end_nxt   = '0;
    inv_ev    = '0;
    codes_nxt = codes_r;
    sts_nxt   = sts_r;
    mask_nxt  = mask_r;
    if (wr_done && addr == REG_STATUS) begin
      sts_nxt = sts_r & ~pwdata;
    end
    if (wr_done && addr == REG_MASK) begin
      mask_nxt = pwdata;
    end
    for (int i = 0; i < PORT_COUNT; i++) begin
      if (link.strobe[i]) begin
        codes_nxt[2*i +: 2] = link.code;
        case (link.code)
          CODE_EXT_FLG:  mclr_nxt[i] = 1'b1;
          CODE_CHAN_FLG: msg_nxt[i]  = 1'b1;
          CODE_SUSPEND:  end_nxt[i]  = 1'b1;
          // Garbled code is taken as suspend and reported back
          default: begin
            end_nxt[i] = 1'b1;
            inv_ev[i]  = 1'b1;
          end
        endcase
      end
    end
    sts_nxt[ST_EXT_LO  +: PORT_COUNT] =
      sts_nxt[ST_EXT_LO +: PORT_COUNT] | mclr_nxt;
    sts_nxt[ST_CHAN_LO +: PORT_COUNT] =
      sts_nxt[ST_CHAN_LO +: PORT_COUNT] | msg_nxt;
    sts_nxt[ST_SUSP_LO +: PORT_COUNT] =
      sts_nxt[ST_SUSP_LO +: PORT_COUNT] | end_nxt;
    sts_nxt[ST_INV_LO  +: PORT_COUNT] =
      sts_nxt[ST_INV_LO +: PORT_COUNT] | inv_ev;
    pirq_nxt = inv_ev;
    if (wr_done && addr == REG_IRQ_SEND) begin
      pirq_nxt = pirq_nxt | pwdata[PORT_COUNT-1:0];
    end
    irq_nxt = |(sts_nxt & mask_nxt);
  end

  // Registers; autoload follows master clear by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_r   <= REG32_RST;
      mask_r  <= REG32_RST;
      codes_r <= WORD_RST;
      pirq_r  <= '0;
      mclr_r  <= '0;
      aload_r <= '0;
      msg_r   <= '0;
      end_r   <= '0;
      irq_r   <= 1'b0;
      rd_r    <= REG32_RST;
      rdy_r   <= 1'b0;
      err_r   <= 1'b0;
    end else if (ce) begin
      sts_r   <= sts_nxt;
      mask_r  <= mask_nxt;
      codes_r <= codes_nxt;
      pirq_r  <= pirq_nxt;
      mclr_r  <= mclr_nxt;
      aload_r <= mclr_r;
      msg_r   <= msg_nxt;
      end_r   <= end_nxt;
      irq_r   <= irq_nxt;
      rd_r    <= rd_nxt;
      rdy_r   <= rdy_nxt;
      err_r   <= err_nxt;
    end
  end

  assign link.periph_irq = pirq_r;
  assign prdata          = rd_r;
  assign pready          = rdy_r;
  // err_r is only ever set together with rdy_r
  assign pslverr         = err_r;
  assign mclr            = mclr_r;
  assign autoload        = aload_r;
  assign msg_read        = msg_r;
  assign xfer_end        = end_r;
  assign irq             = irq_r;

endmodule

`default_nettype wire

// [verif/ppc_checker.sv]
/*
  Link checker: watches code, strobe and interrupt lines.
  Assumes one clock shared by both ends of the link.
*/
`timescale 1ns/1ps
`default_nettype none

module ppc_checker
  import ppc_pkg::*;
(
  // Clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  ce,
  // Link lines
  input wire logic [1:0]            code,
  input wire logic [PORT_COUNT-1:0] strobe,
  input wire logic [PORT_COUNT-1:0] periph_irq
);
  // Whole link runs on one clock, quiet under reset
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_strobe_onehot: assert property ($onehot0(strobe))
    else $error("strobe on several ports");
  a_strobe_single: assert property ((|strobe) |=> (strobe == '0))
    else $error("strobe longer than one cycle");
  a_code_by_strobe: assert property ($changed(code) |-> (|strobe))
    else $error("code moved without strobe");
  a_code_holds: assert property ((|strobe) |=> $stable(code))
    else $error("code not held after strobe");
  a_invalid_irq: assert property (
    ((|strobe) && code == CODE_INVALID) |=>
      ((periph_irq & $past(strobe)) == $past(strobe)))
    else $error("no interrupt after invalid code");
  a_frozen_link: assert property (
    !ce |=> ($stable(code) && $stable(strobe) && $stable(periph_irq)))
    else $error("link moved while clock enable low");
endmodule

`default_nettype wire

// [verif/test_peripheral_port_channel_ctrl.sv]
/*
  Self-checking bench joining port group and station end.
  Assumes package, link interface and checker compile first.
*/
`timescale 1ns/1ps
`default_nettype none

module test_peripheral_port_channel_ctrl
  import ppc_pkg::*;
;
  logic        pclk, presetn, ce, sel_wr, cmd_wr, cpl_par_err, er;
  logic        psel, penable, pwrite, pready, pslverr, irq;
  logic [15:0] wr_data, parity_status_word, composite_status_word;
  logic [7:0]  port_par_err, eirq, eerr;
  logic [23:0] port_bank, pb;
  logic [2:0]  cpl_bank;
  logic [2:0]  bk [8];
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rnd, sv, act;
  logic        clr_act, cplclr_o;
  logic [7:0]  mclr_o, aload_o, msg_o, xend_o, opclr_o;
  logic [8:0]  oc;
  int          n_tests, n_mismatch, i, k;

  ppc_link_if ppc_link_if_i ();
  ppc_port_group ppc_port_group_i (.pclk(pclk), .presetn(presetn),
    .ce(ce), .link(ppc_link_if_i), .sel_wr(sel_wr), .cmd_wr(cmd_wr),
    .wr_data(wr_data), .parity_status_word(parity_status_word),
    .composite_status_word(composite_status_word),
    .port_par_err(port_par_err), .port_bank(port_bank),
    .cpl_par_err(cpl_par_err), .cpl_bank(cpl_bank), .op_clear(opclr_o),
    .cpl_op_clear(cplclr_o));
  ppc_station_end ppc_station_end_i (.pclk(pclk), .presetn(presetn),
    .ce(ce), .link(ppc_link_if_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mclr(mclr_o), .autoload(aload_o),
    .msg_read(msg_o), .xfer_end(xend_o), .irq(irq));
  ppc_checker ppc_checker_i (.pclk(pclk), .presetn(presetn), .ce(ce),
    .code(ppc_link_if_i.code), .strobe(ppc_link_if_i.strobe),
    .periph_irq(ppc_link_if_i.periph_irq));

  // 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Expectations, worked out from the word layouts
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h8020_0003 : 32'h0);
  endfunction
  function automatic logic [15:0] selw(input int k);
    return {CONNECT_CODE[0], CONNECT_CODE[1], CONNECT_CODE[2],
            CONNECT_CODE[3], 4'h0, 8'h80 >> k};
  endfunction
  function automatic logic [31:0] pexp(input logic [2:0] b, input logic e);
    return {16'h0, eerr, 4'h0, b[0], b[1], b[2], e};
  endfunction
  function automatic logic [31:0] cexp(input logic e);
    return {16'h0, eirq, 7'h0, e};
  endfunction
  function automatic logic [31:0] stexp(input int k, input logic [1:0] c);
    return (32'h1 << (k + (c == 2'h1 ? 8 : c == 2'h2 ? 0 : 16)))
           | (c == 2'h0 ? 32'h1 << (k + 24) : 32'h0);
  endfunction
  function automatic logic [31:0] aexp(input int k, input logic [1:0] c);
    return (c == 2'h2 ? 32'h0101_0000 : c == 2'h1 ? 32'h100 : 32'h1) << k;
  endfunction

  // Sticky record of action pulses, so a one-cycle pulse is not missed
  always @(posedge pclk) begin
    act <= clr_act ? 32'h0 : act | {aload_o, mclr_o, msg_o, xend_o};
    oc  <= clr_act ? 9'h000 : oc | {cplclr_o, opclr_o};
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Processor word write; waits until status has settled
  task automatic pw(input logic s, input logic [15:0] d);
    {sel_wr, cmd_wr} <= {s, ~s};
    wr_data <= d;
    @(posedge pclk);
    {sel_wr, cmd_wr} <= 2'b00;
    repeat (2) @(posedge pclk);
  endtask

  // Strobe rises with the code, then the word is cleared at once
  task automatic send(input logic [1:0] cd);
    pw(1'b0, {1'b1, cd[0], cd[1], 13'h0});
    pw(1'b0, 16'h0000);
  endtask

  // APB transfer; an edge passes before the next setup
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // No limit here: the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask

  task automatic final_report;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    final_report();
  end

  // Main sequence
  initial begin
    {presetn, sel_wr, cmd_wr, cpl_par_err, psel, penable, pwrite} = '0;
    {wr_data, port_par_err, port_bank, cpl_bank, paddr, pwdata} = '0;
    {n_tests, n_mismatch, eirq, eerr} = '0;
    ce = 1'b1;
    clr_act = 1'b1;
    rnd = 32'h85e8;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(parity_status_word | composite_status_word), 32'h0);
    apb(1'b0, REG_MASK, 32'h0);
    chk(rd, REG32_RST);
    apb(1'b0, 12'h010, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    $display("reset and map test done");
    // Every code, random port, mask on or off
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      k = int'(rnd[2:0]);
      apb(1'b1, REG_MASK, {32{rnd[7]}});
      clr_act <= 1'b1;
      pw(1'b1, selw(k));
      clr_act <= 1'b0;
      send(i[1:0]);
      chk(act, aexp(k, i[1:0]));
      apb(1'b0, REG_CODES, 32'h0);
      chk(32'(rd[2*k +: 2]), 32'(i[1:0]));
      apb(1'b0, REG_STATUS, 32'h0);
      chk(rd, stexp(k, i[1:0]));
      chk(32'(irq), 32'(rnd[7]));
      apb(1'b1, REG_STATUS, 32'hffff_ffff);
      if (i[1:0] == CODE_INVALID) eirq[k] = 1'b1;
      chk(32'(composite_status_word), cexp(1'b0));
    end
    $display("control code test done");
    apb(1'b1, REG_IRQ_SEND, 32'hff);
    eirq = 8'hff;
    for (i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      k = int'(rnd[2:0]);
      pw(1'b1, selw(k));
      pw(1'b0, 16'h0800);
      pw(1'b0, 16'h0000);
      eirq[k] = 1'b0;
      chk(32'(composite_status_word), cexp(1'b0));
    end
    $display("interrupt clear test done");
    // Wrong connect code, then two ports at once: both refused
    apb(1'b0, REG_CODES, 32'h0);
    sv = rd;
    pw(1'b1, {rnd[3:0] == 4'hc ? 4'h9 : rnd[3:0], 12'h080});
    chk(32'(parity_status_word | composite_status_word), 32'h0);
    send(CODE_SUSPEND);
    pw(1'b1, 16'hc081);
    send(CODE_EXT_FLG);
    apb(1'b0, REG_CODES, 32'h0);
    chk(rd, sv);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h0);
    $display("refusal test done");
    // Port parity errors; bank kept from the first one
    for (i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      k = int'(rnd[2:0]);
      pb = rnd[31:8];
      pb[3*k +: 3] = rnd[5:3];
      {port_bank, port_par_err} <= {pb, 8'h01 << k};
      @(posedge pclk);
      port_par_err <= 8'h00;
      if (!eerr[k]) bk[k] = rnd[5:3];
      eerr[k] = 1'b1;
      clr_act <= 1'b1;
      pw(1'b1, selw(k));
      clr_act <= 1'b0;
      chk(32'(parity_status_word), pexp(bk[k], 1'b0));
      chk(32'(composite_status_word), cexp(1'b1));
      if (rnd[6]) begin
        pw(1'b0, 16'h1000);
        pw(1'b0, 16'h0000);
        eerr[k] = 1'b0;
        chk(32'(parity_status_word), pexp(3'h0, 1'b0));
      end
      chk(32'(oc), rnd[6] ? 32'h1 << k : 32'h0);
    end
    {cpl_bank, cpl_par_err} <= {rnd[10:8], 1'b1};
    @(posedge pclk);
    cpl_par_err <= 1'b0;
    clr_act <= 1'b1;
    pw(1'b1, 16'hc100);
    clr_act <= 1'b0;
    chk(32'(parity_status_word), pexp(rnd[10:8], 1'b1));
    chk(32'(composite_status_word[0]), 32'h1);
    // Frozen block must ignore a program clear
    ce <= 1'b0;
    pw(1'b0, 16'h1000);
    pw(1'b0, 16'h0000);
    ce <= 1'b1;
    chk(32'(parity_status_word), pexp(rnd[10:8], 1'b1));
    pw(1'b0, 16'h1000);
    pw(1'b0, 16'h0000);
    chk(32'(parity_status_word), pexp(3'h0, 1'b0));
    chk(32'(oc), 32'h100);
    $display("parity test done");
    final_report();
  end
endmodule

`default_nettype wire
